// ===== verification/mds_mem_model.sv
// Element memory model: read word valid late in each cycle
`timescale 1ns/1ps
module mds_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        cycle_busy,
  input  wire logic [63:0] word,
  output logic      [63:0] memory_read_data
);
  logic [6:0]  cnt_ff;
  logic        vld_ff;
  logic [63:0] dat_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= 7'h00;
      vld_ff <= 1'b0;
      dat_ff <= 64'h0;
    end else begin
      cnt_ff <= cycle_busy ? cnt_ff + 7'h01 : 7'h00;
      if (cnt_ff == 7'h1B) begin
        vld_ff <= 1'b1;
        dat_ff <= word;
      end else if (cnt_ff == 7'h12) begin
        vld_ff <= 1'b0;
      end
    end
  end
  // Outside the valid window show the inverse so stale data cannot pass
  assign memory_read_data = vld_ff ? dat_ff : ~dat_ff;
endmodule : mds_mem_model

// ===== verification/mds_switch_sva.sv
// Assertion checker for the memory data switch ports
`timescale 1ns/1ps
module mds_switch_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [63:0] memory_write_data,
  input wire logic        memory_write_valid,
  input wire logic [63:0] pe_output_data,
  input wire logic [63:0] buffer_io_output_data,
  input wire logic [7:0]  latch_strobe,
  input wire logic        output_gate_enable,
  input wire logic        transfer_gate_enable,
  input wire logic        cycle_busy
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_strobe_time: assert property ($rose(cycle_busy) |-> ##6
    latch_strobe == 8'h00 ##1 latch_strobe == 8'hFF ##1 latch_strobe == 8'h00)
    else $error("latch strobe out of place");
  a_strobe_even: assert property (latch_strobe == 8'h00 ||
    latch_strobe == 8'hFF) else $error("byte strobes differ");
  a_te_onset: assert property ($rose(transfer_gate_enable) |->
    $past(cycle_busy, 21) && !$past(cycle_busy, 22))
    else $error("transfer period starts late or early");
  a_te_length: assert property ($rose(transfer_gate_enable) |->
    ##11 transfer_gate_enable ##1 !transfer_gate_enable)
    else $error("transfer period length wrong");
  a_oe_onset: assert property ($rose(output_gate_enable) |->
    $past(cycle_busy, 34) && !$past(cycle_busy, 35))
    else $error("output period starts late or early");
  a_oe_length: assert property ($rose(output_gate_enable) |->
    ##11 output_gate_enable ##1 !output_gate_enable)
    else $error("output period length wrong");
  a_path_single: assert property (!(output_gate_enable &&
    transfer_gate_enable) && !(transfer_gate_enable && memory_write_valid))
    else $error("two paths active");
  a_oe_data: assert property ($rose(output_gate_enable) |->
    buffer_io_output_data == pe_output_data) else $error("read not steered");
  a_te_data: assert property ($rose(transfer_gate_enable) |->
    buffer_io_output_data == memory_write_data)
    else $error("transfer not steered");
  a_wv_length: assert property ($rose(memory_write_valid) |->
    ##22 memory_write_valid ##1 !memory_write_valid)
    else $error("write data hold length wrong");
  a_wd_steady: assert property (memory_write_valid &&
    $past(memory_write_valid) |-> $stable(memory_write_data))
    else $error("held write data moved");
  a_busy_length: assert property ($rose(cycle_busy) |->
    ##74 cycle_busy ##1 !cycle_busy) else $error("cycle length wrong");
endmodule : mds_switch_sva

bind mds_switch mds_switch_sva chk_u (
  .hclk, .hresetn, .memory_write_data, .memory_write_valid, .pe_output_data,
  .buffer_io_output_data, .latch_strobe, .output_gate_enable,
  .transfer_gate_enable, .cycle_busy
);

// ===== verification/test_memory_data_switch.sv
// Testbench for the memory data switch
`timescale 1ns/1ps
module test_memory_data_switch;
  typedef struct packed {
    logic        t, o, i, p, s;
    logic [1:0]  r, src, dst;
    logic [63:0] m;
  } mds_row_s;
  localparam logic [63:0] ALL = 64'hFFFFFFFF_FFFFFFFF;
  localparam logic [63:0] OUT = 64'hFFFFFF00_000000FF;
  localparam logic [63:0] INN = 64'h000000FF_FFFFFF00;
  mds_row_s rows [9] = '{
    '{0, 1, 1, 1, 0, 0, 0, 0, ALL}, '{0, 1, 0, 1, 0, 0, 0, 0, OUT},
    '{0, 0, 1, 1, 0, 0, 0, 0, INN}, '{0, 1, 1, 0, 1, 0, 1, 0, ALL},
    '{0, 1, 1, 1, 1, 0, 1, 0, ALL}, '{1, 1, 1, 1, 0, 0, 0, 1, ALL},
    '{1, 0, 1, 1, 0, 0, 0, 1, INN}, '{0, 0, 0, 0, 0, 2, 2, 2, ALL},
    '{0, 0, 0, 0, 0, 1, 2, 2, ALL}};
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic cycle_initiate = 1'b0, transfer_cycle = 1'b0;
  logic outer_word_enable = 1'b0, inner_word_enable = 1'b0;
  logic pe_write_transfer_select = 1'b0, io_write_select = 1'b0;
  logic buffer_read_select = 1'b0, io_read_select = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [63:0] pe_input_data = 64'h0, io_write_data = 64'h0, mem_word = 64'h0;
  logic [63:0] memory_read_data, memory_write_data, pe_output_data, e;
  logic [63:0] buffer_io_output_data, pe, io, mw;
  logic [7:0]  latch_strobe;
  logic hreadyout, hresp, memory_write_valid, output_gate_enable, cycle_busy;
  logic transfer_gate_enable, outer_word_enable_latched;
  logic inner_word_enable_latched, buffer_read_select_latched;
  logic io_read_select_latched;
  wire  hready = hreadyout;
  wire  clk_en = 1'b1;
  int   err_total = 0, tests_run = 0;

  always #4 hclk = ~hclk;

  mds_switch dut_u (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .cycle_initiate,
    .transfer_cycle, .outer_word_enable, .inner_word_enable,
    .pe_write_transfer_select, .io_write_select, .buffer_read_select,
    .io_read_select, .pe_input_data, .io_write_data, .memory_read_data,
    .memory_write_data, .memory_write_valid, .pe_output_data,
    .buffer_io_output_data, .latch_strobe, .output_gate_enable,
    .transfer_gate_enable, .outer_word_enable_latched,
    .inner_word_enable_latched, .buffer_read_select_latched,
    .io_read_select_latched, .cycle_busy);
  mds_mem_model mem_u (.hclk, .hresetn, .cycle_busy, .word(mem_word),
    .memory_read_data);

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [63:0] x, y);
    tests_run++;
    if (y !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, y);
    end
  endtask : chk

  task automatic edges(input int n, input logic lv);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while ((hready !== 1'b1 || lv) && cycle_busy !== 1'b0 && k < n);
  endtask : edges

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= mds_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, a};
    hwrite <= w;
    edges(100, 1'b0);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    edges(100, 1'b0);
    r = hrdata;
  endtask : ahb

  task automatic run(input mds_row_s w);
    {transfer_cycle, outer_word_enable, inner_word_enable} <= {w.t, w.o, w.i};
    {pe_write_transfer_select, io_write_select} <= {w.p, w.s};
    {buffer_read_select, io_read_select} <= w.r;
    mem_word <= mw;
    pe_input_data <= ~pe;
    io_write_data <= ~io;
    cycle_initiate <= 1'b1;
    @(posedge hclk);
    cycle_initiate <= 1'b0;
    repeat (5) @(posedge hclk);
    pe_input_data <= pe;
    io_write_data <= io;
    repeat (4) @(posedge hclk);
    pe_input_data <= ~pe;
    io_write_data <= ~io;
    cycle_initiate <= 1'b1;
    @(posedge hclk);
    cycle_initiate <= 1'b0;
    edges(200, 1'b1);
    chk("busy_end", 64'h0, {63'h0, cycle_busy});
  endtask : run

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk("busy", 64'h0, {63'h0, cycle_busy});
    chk("valid", 64'h0, {63'h0, memory_write_valid});
    ahb(1'b0, mds_pkg::A_CTRL, 32'h0);
    chk("ctrl", 64'h1, {32'h0, r});
    chk("hresp", 64'h0, {63'h0, hresp});
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 64'h0, {32'h0, r});
    for (int k = 0; k < 9; k++) begin
      pe = 64'h01234567_89ABCDEF + 64'(k);
      io = 64'h5A3C96F0_0F69C3A5 + 64'(k);
      mw = 64'hC0FFEE12_3456789A + 64'(k);
      run(rows[k]);
      e = rows[k].src == 2'h0 ? ~pe : (rows[k].src == 2'h1 ? io : mw);
      chk("outer_l", {63'h0, rows[k].o}, {63'h0, outer_word_enable_latched});
      chk("inner_l", {63'h0, rows[k].i}, {63'h0, inner_word_enable_latched});
      if (rows[k].dst == 2'h0)
        chk("write", e & rows[k].m, memory_write_data & rows[k].m);
      if (rows[k].dst != 2'h0)
        chk("bufio", e & rows[k].m, buffer_io_output_data & rows[k].m);
      if (rows[k].dst == 2'h2)
        chk("pe_out", e, pe_output_data);
    end
    pe = 64'h0F1E2D3C_4B5A6978;
    run(rows[0]);
    ahb(1'b0, mds_pkg::A_HOLD_LO, 32'h0);
    chk("hold_lo", {32'h0, ~pe[31:0]}, {32'h0, r});
    ahb(1'b0, mds_pkg::A_HOLD_HI, 32'h0);
    chk("hold_hi", {32'h0, ~pe[63:32]}, {32'h0, r});
    ahb(1'b1, mds_pkg::A_CTRL, 32'h0);
    cycle_initiate <= 1'b1;
    @(posedge hclk);
    cycle_initiate <= 1'b0;
    repeat (3) @(posedge hclk);
    chk("refused", 64'h0, {63'h0, cycle_busy});
    ahb(1'b1, mds_pkg::A_CTRL, 32'h3);
    repeat (3) @(posedge hclk);
    edges(200, 1'b1);
    ahb(1'b0, mds_pkg::A_CYCLES, 32'h0);
    chk("cycles", 64'd11, {32'h0, r});
    // Reset in the middle of a cycle
    cycle_initiate <= 1'b1;
    @(posedge hclk);
    cycle_initiate <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk("rst_busy", 64'h0, {63'h0, cycle_busy});
    chk("rst_hold", 64'h0, memory_write_data);
    chk("rst_valid", 64'h0, {63'h0, memory_write_valid});
    hresetn <= 1'b1;
    ahb(1'b0, mds_pkg::A_CYCLES, 32'h0);
    chk("rst_cycles", 64'h0, {32'h0, r});
    final_report();
  end
endmodule : test_memory_data_switch

// ===== verilog/mds_pkg.sv
// Shared constants for the memory data switch
package mds_pkg;

  localparam int CLK_NS = 8;
  localparam int DW     = 64;
  localparam int NBYTE  = 8;

  // Rounds a least time up to whole cycles, never below one
  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : ceil_cyc

  // Rounds a longest time down to whole cycles, never below one
  function automatic int floor_cyc(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : floor_cyc

  // Event times from the start of a cycle, ns
  localparam int STROBE_NS   = 55;
  localparam int STROBE_W_NS = 8;
  localparam int RSEL_NS     = 130;
  localparam int TE_SET_NS   = 165;
  localparam int TE_CLR_NS   = 265;
  localparam int RD_PE_NS    = 235;
  localparam int WR_HOLD_NS  = 250;
  localparam int OE_SET_NS   = 270;
  localparam int OE_CLR_NS   = 370;
  localparam int STAGES      = 12;
  localparam int STAGE_NS    = 50;
  localparam int TAP_STEP_NS = 5;
  localparam int CHAIN_NS    = STAGES * STAGE_NS;

  // Counter value at which each event is taken (edge count minus one); C_STR_W is the strobe width in cycles
  localparam logic [6:0] C_STROBE = 7'(ceil_cyc(STROBE_NS) - 1);
  localparam logic [6:0] C_STR_W  = 7'(floor_cyc(STROBE_W_NS));
  localparam logic [6:0] C_RSEL   = 7'(ceil_cyc(RSEL_NS) - 1);
  localparam logic [6:0] C_TE_SET = 7'(ceil_cyc(TE_SET_NS) - 1);
  localparam logic [6:0] C_TE_CLR = 7'(floor_cyc(TE_CLR_NS) - 1);
  localparam logic [6:0] C_RD_PE  = 7'(ceil_cyc(RD_PE_NS) - 1);
  localparam logic [6:0] C_WR_CLR = 7'(floor_cyc(WR_HOLD_NS) - 1);
  localparam logic [6:0] C_OE_SET = 7'(ceil_cyc(OE_SET_NS) - 1);
  localparam logic [6:0] C_OE_CLR = 7'(floor_cyc(OE_CLR_NS) - 1);
  localparam logic [6:0] C_END    = 7'(floor_cyc(CHAIN_NS) - 1);

  // Bytes of the inner word (bits 8..39), the rest form the outer word
  localparam logic [7:0] INNER_BYTES = 8'h1E;

  // Register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_HOLD_LO = 8'h08;
  localparam logic [7:0] A_HOLD_HI = 8'h0C;
  localparam logic [7:0] A_CYCLES  = 8'h10;

  localparam int CTRL_EN    = 0;
  localparam int CTRL_START = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    MDS_IDLE = 2'b01,
    MDS_RUN  = 2'b10
  } mds_state_e;

endpackage : mds_pkg

// ===== verilog/mds_switch.sv
// Memory data switch: holding latches, read/transfer selector, timing
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps

// How it works
// - Selector forwards read or transfer data to I/O
// - Choose PE or I/O write data into latches
// - Holding latches keep write and transfer data
// - Datapath is eight byte slices of eight bits
// - Inner word bits 8-39 of PE data gated by inner enable
// - Outer word bytes of PE data gated by outer enable
// - I/O write select gates I/O data in
// - PE select ANDed with each latched word enable
// - Eight byte strobes near 55 ns, 8 ns wide
// - Output enable steers read data out
// - Transfer enable steers held transfer data out
// - Output bus valid in transfer and output periods
// - Read data to PE valid 235 to 165 ns
// - Write data to memory held about 250 ns
// - PE input data bits are inverted polarity
// - Twelve 50 ns stages timed in 5 ns steps; the counter here steps 8 ns
// - Word enables latched early, kept whole cycle
// - Buffer and I/O read selects latched at a tap
// - Buffer read select set at 130 ns, held through output
// - Output period from 270 ns to 370 ns
// - Transfer period from 165 ns to 265 ns
module mds_switch (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cycle_initiate,
  input  wire logic        transfer_cycle,
  input  wire logic        outer_word_enable,
  input  wire logic        inner_word_enable,
  input  wire logic        pe_write_transfer_select,
  input  wire logic        io_write_select,
  input  wire logic        buffer_read_select,
  input  wire logic        io_read_select,
  input  wire logic [63:0] pe_input_data,
  input  wire logic [63:0] io_write_data,
  input  wire logic [63:0] memory_read_data,
  output logic      [63:0] memory_write_data,
  output logic             memory_write_valid,
  output logic      [63:0] pe_output_data,
  output logic      [63:0] buffer_io_output_data,
  output logic      [7:0]  latch_strobe,
  output logic             output_gate_enable,
  output logic             transfer_gate_enable,
  output logic             outer_word_enable_latched,
  output logic             inner_word_enable_latched,
  output logic             buffer_read_select_latched,
  output logic             io_read_select_latched,
  output logic             cycle_busy
);

  // Timing chain
  mds_pkg::mds_state_e st_ff;
  mds_pkg::mds_state_e nxt_st;
  logic [6:0]  cnt_ff;
  logic [6:0]  nxt_cnt;
  logic        running;
  logic        start;
  logic [7:0]  strb_ff;
  logic        xfer_ff;
  logic        wr_src_ff;

  // Register file
  logic [1:0]  ctrl_ff;
  logic [31:0] cycles_ff;
  logic        ph_wr_ff;
  logic [7:0]  ph_addr_ff;
  logic        sw_start;

  // Datapath
  logic [63:0] hold_ff;
  logic [63:0] pe_data_pos;
  logic [63:0] src_data;
  logic [7:0]  src_byte_en;
  logic [7:0]  byte_load;
  logic        outer_ff;
  logic        inner_ff;
  logic        pe_path;
  logic        io_path;
  logic        te_ff;
  logic        oe_ff;
  logic        brs_ff;
  logic        iors_ff;
  logic        mwv_ff;
  logic [63:0] pe_out_ff;
  logic [63:0] bio_ff;
  logic        read_cyc;

  function automatic logic tap(input logic [6:0] c, input logic [6:0] k);
    return c == k;
  endfunction : tap

  assign running = (st_ff == mds_pkg::MDS_RUN);
  assign sw_start = ph_wr_ff & (ph_addr_ff == mds_pkg::A_CTRL)
                  & hwdata[mds_pkg::CTRL_START];
  assign start = ~running
               & ((cycle_initiate & ctrl_ff[mds_pkg::CTRL_EN]) | sw_start);

  // Counter stands in for the series delay stages
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    unique case (st_ff)
      mds_pkg::MDS_IDLE: begin
        if (start) begin
          nxt_st  = mds_pkg::MDS_RUN;
          nxt_cnt = '0;
        end
      end
      mds_pkg::MDS_RUN: begin
        if (tap(cnt_ff, mds_pkg::C_END)) begin
          nxt_st = mds_pkg::MDS_IDLE;
        end
        nxt_cnt = cnt_ff + 7'h01;
      end
      default: begin
        nxt_st = mds_pkg::MDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff  <= mds_pkg::MDS_IDLE;
      cnt_ff <= 7'h00;
    end else if (clk_en) begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
    end
  end

  // Word enables and cycle kind caught as the cycle starts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      outer_ff  <= 1'b0;
      inner_ff  <= 1'b0;
      xfer_ff   <= 1'b0;
      wr_src_ff <= 1'b0;
    end else if (clk_en && start) begin
      outer_ff  <= outer_word_enable;
      inner_ff  <= inner_word_enable;
      xfer_ff   <= transfer_cycle;
      wr_src_ff <= io_write_select | pe_write_transfer_select;
    end
  end

  // Read destinations held until the output period closes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      brs_ff  <= 1'b0;
      iors_ff <= 1'b0;
    end else if (clk_en && running) begin
      if (tap(cnt_ff, mds_pkg::C_RSEL)) begin
        brs_ff  <= buffer_read_select;
        iors_ff <= io_read_select;
      end else if (tap(cnt_ff, mds_pkg::C_OE_CLR)) begin
        brs_ff  <= 1'b0;
        iors_ff <= 1'b0;
      end
    end
  end

  // One strobe per byte slice
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strb_ff <= 8'h00;
    end else if (clk_en) begin
      strb_ff <= {mds_pkg::NBYTE{running
                 & tap(cnt_ff, mds_pkg::C_STROBE)}};
    end
  end

  // Source selection; I/O wins so only one path loads
  assign pe_data_pos = ~pe_input_data;
  assign io_path = io_write_select;
  assign pe_path = pe_write_transfer_select & ~io_write_select;
  assign src_data = io_path ? io_write_data : pe_data_pos;
  assign src_byte_en = io_path ? 8'hFF
                     : {mds_pkg::NBYTE{pe_path}}
                       & ((mds_pkg::INNER_BYTES & {8{inner_ff}})
                       | (~mds_pkg::INNER_BYTES & {8{outer_ff}}));
  assign byte_load = strb_ff & src_byte_en;

  // Holding latches, one byte slice each
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_ff <= 64'h0;
    end else if (clk_en) begin
      for (int b = 0; b < mds_pkg::NBYTE; b++) begin
        if (byte_load[b]) begin
          hold_ff[b*8 +: 8] <= src_data[b*8 +: 8];
        end
      end
    end
  end

  // Memory write window opens with the load, closes near 250 ns
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mwv_ff <= 1'b0;
    end else if (clk_en) begin
      if (running && tap(cnt_ff, mds_pkg::C_WR_CLR)) begin
        mwv_ff <= 1'b0;
      end else if (running && tap(cnt_ff, mds_pkg::C_STROBE + 7'h01)
                   && !xfer_ff && wr_src_ff) begin
        mwv_ff <= 1'b1;
      end
    end
  end

  assign read_cyc = brs_ff | iors_ff;

  // Memory read data taken after it settles, held to next capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pe_out_ff <= 64'h0;
    end else if (clk_en && running && !xfer_ff
                 && tap(cnt_ff, mds_pkg::C_RD_PE)) begin
      pe_out_ff <= memory_read_data;
    end
  end

  // Transfer and output periods with their selector data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      te_ff  <= 1'b0;
      oe_ff  <= 1'b0;
      bio_ff <= 64'h0;
    end else if (clk_en && running) begin
      if (tap(cnt_ff, mds_pkg::C_TE_SET) && xfer_ff) begin
        te_ff  <= 1'b1;
        bio_ff <= hold_ff;
      end else if (tap(cnt_ff, mds_pkg::C_TE_CLR)) begin
        te_ff <= 1'b0;
      end
      if (tap(cnt_ff, mds_pkg::C_OE_SET) && read_cyc && !xfer_ff) begin
        oe_ff  <= 1'b1;
        bio_ff <= pe_out_ff;
      end else if (tap(cnt_ff, mds_pkg::C_OE_CLR)) begin
        oe_ff <= 1'b0;
      end
    end
  end

  // AHB-Lite slave, zero wait states, stalls while the clock is held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_ff   <= 1'b0;
      ph_addr_ff <= 8'h00;
    end else if (clk_en) begin
      ph_wr_ff   <= hsel & hready & htrans[1] & hwrite;
      ph_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff   <= mds_pkg::CTRL_RST;
      cycles_ff <= 32'h0;
    end else if (clk_en) begin
      if (ph_wr_ff && ph_addr_ff == mds_pkg::A_CTRL) begin
        ctrl_ff <= {1'b0, hwdata[mds_pkg::CTRL_EN]};
      end
      if (running && tap(cnt_ff, mds_pkg::C_END)) begin
        cycles_ff <= cycles_ff + 32'h1;
      end
    end
  end

  logic [7:0]  rd_addr_ff;
  logic [31:0] rd_mux;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_addr_ff <= 8'hFF;
    end else if (clk_en && hsel && hready) begin
      rd_addr_ff <= haddr[7:0];
    end
  end

  always_comb begin
    unique case (rd_addr_ff)
      mds_pkg::A_CTRL:    rd_mux = {30'h0, ctrl_ff};
      mds_pkg::A_STATUS:  rd_mux = {16'h0, 1'b0, cnt_ff, mwv_ff,
                                    oe_ff, te_ff, iors_ff, brs_ff,
                                    inner_ff, outer_ff, running};
      mds_pkg::A_HOLD_LO: rd_mux = hold_ff[31:0];
      mds_pkg::A_HOLD_HI: rd_mux = hold_ff[63:32];
      mds_pkg::A_CYCLES:  rd_mux = cycles_ff;
      default:            rd_mux = 32'h0;
    endcase
  end

  assign hrdata    = rd_mux;
  assign hreadyout = clk_en;
  assign hresp     = 1'b0;

  assign memory_write_data          = hold_ff;
  assign memory_write_valid         = mwv_ff;
  assign pe_output_data             = pe_out_ff;
  assign buffer_io_output_data      = bio_ff;
  assign latch_strobe               = strb_ff;
  assign output_gate_enable         = oe_ff;
  assign transfer_gate_enable       = te_ff;
  assign outer_word_enable_latched  = outer_ff;
  assign inner_word_enable_latched  = inner_ff;
  assign buffer_read_select_latched = brs_ff;
  assign io_read_select_latched     = iors_ff;
  assign cycle_busy                 = running;

endmodule : mds_switch
